/* rtl/axis_guard_pkg.sv */
// shared constants and types for the axis guard and status logic
package axis_guard_pkg;

  // clock and time base
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int BLINK_TIME_MS = 500;
  localparam int BLINK_CYCLES = BLINK_TIME_MS * CLK_FREQ_KHZ;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES = TICK_TIME_MS * CLK_FREQ_KHZ;

  // data widths
  localparam int POS_W = 32;
  localparam int ACC_W = 16;
  localparam int LOAD_W = 16;
  localparam int TORQ_W = 16;
  localparam int DLY_W = 16;
  localparam int PNUM_W = 8;

  // point flag field positions
  localparam int FLAG_PAYLOAD_BIT = 0;
  localparam int FLAG_STOP_BIT = 1;

  // error alarm table, ascending code order so lowest index is highest priority
  localparam int NUM_ALARMS = 20;
  localparam logic [PNUM_W-1:0] ALARM_CODES [NUM_ALARMS] = '{
    8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A,
    8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93, 8'hC1, 8'hC2};
  localparam logic [NUM_ALARMS-1:0] ALARM_EXTERNAL = 20'hC0000;

  // values after reset
  localparam logic [PNUM_W-1:0] PNUM_RST = 8'h00;
  localparam logic STOP_OPEN_RST = 1'b0;
  localparam logic [31:0] CNT_RST = 32'h0;
  localparam logic [DLY_W-1:0] DLY_RST = 16'h0;

  // open stop mode holding sequence
  typedef enum logic [1:0] {HOLD_IDLE, HOLD_WAIT, HOLD_ON} hold_state_t;

endpackage : axis_guard_pkg

/* rtl/alarm_sel_if.sv */
// carrier for the selected error alarm between priority logic and status logic
`timescale 1ns/1ps
`default_nettype none
interface alarm_sel_if;
  logic active;
  logic [7:0] code;
  logic external;
  modport prod (output active, output code, output external);
  modport cons (input active, input code, input external);
endinterface : alarm_sel_if
`default_nettype wire

/* rtl/alarm_priority.sv */
// fixed priority pick of the active error alarm
`timescale 1ns/1ps
`default_nettype none
module alarm_priority
  import axis_guard_pkg::*;
(
  input wire logic [NUM_ALARMS-1:0] active_i,
  alarm_sel_if.prod sel
);

  // scan downward so the smallest code overwrites the rest
  always_comb begin
    sel.active = |active_i;
    sel.code = PNUM_RST;
    sel.external = 1'b0;
    for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
      if (active_i[i]) begin
        sel.code = ALARM_CODES[i];
        sel.external = ALARM_EXTERNAL[i];
      end
    end
  end

endmodule : alarm_priority
`default_nettype wire

/* rtl/axis_guard_status_logic.sv */
// motion guard, zone, alarm number output, stop mode and lamp logic for one axis
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - reject targets below lower or above upper soft limit, accept inside
// - axis inside range, target inside range: move permitted
// - axis outside range, target inside range: move still permitted
// - zone output high while current position lies within zone bounds
// - active error alarm number shown in binary on point-number outputs
// - several alarms active: only highest-priority number is output
// - alarm number shown only when output enable set, else normal point number
// - flag bit 0 clear picks first payload, set picks second payload
// - custom acceleration clamped to selected payload ceiling
// - point move done: flag bit 1 clear closed stop, set open stop
// - non point-trace moves take stop mode from default stop mode setting
// - open stop mode holds torque, no feedback position correction
// - holding torque magnitude and its delay come from settings
// - power lamp dark without power, blinks servo off, lit servo on
// - fault lamp dark no alarm, blinks external, lit internal alarm
module axis_guard_status_logic
  import axis_guard_pkg::*;
#(
  parameter int BLINK_CNT = BLINK_CYCLES,
  parameter int TICK_CNT = TICK_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic signed [POS_W-1:0] SOFT_LIMIT_LOWER_I,
  input wire logic signed [POS_W-1:0] SOFT_LIMIT_UPPER_I,
  input wire logic signed [POS_W-1:0] ZONE_LOWER_BOUND_I,
  input wire logic signed [POS_W-1:0] ZONE_UPPER_BOUND_I,
  input wire logic signed [POS_W-1:0] CUR_POS_I,
  input wire logic signed [POS_W-1:0] TARGET_POS_I,
  input wire logic MOVE_REQ_I,
  input wire logic MOVE_IS_POINT_I,
  input wire logic [1:0] POINT_FLAGS_I,
  input wire logic [LOAD_W-1:0] FIRST_PAYLOAD_SETTING_I,
  input wire logic [LOAD_W-1:0] SECOND_PAYLOAD_SETTING_I,
  input wire logic [ACC_W-1:0] FIRST_ACCEL_CEIL_I,
  input wire logic [ACC_W-1:0] SECOND_ACCEL_CEIL_I,
  input wire logic CUSTOM_ACCEL_I,
  input wire logic [ACC_W-1:0] REQ_ACCEL_I,
  input wire logic MOVE_DONE_I,
  input wire logic DEFAULT_STOP_MODE_I,
  input wire logic [TORQ_W-1:0] HOLD_TORQUE_SETTING_I,
  input wire logic [DLY_W-1:0] HOLD_DELAY_MS_I,
  input wire logic [PNUM_W-1:0] POINT_NUM_I,
  input wire logic ALARM_CODE_OUTPUT_ENABLE_I,
  input wire logic [NUM_ALARMS-1:0] ALARM_ACTIVE_I,
  input wire logic CTRL_POWER_I,
  input wire logic SERVO_ON_I,
  output logic MOVE_ACCEPT_O,
  output logic MOVE_REJECT_O,
  output logic [LOAD_W-1:0] PAYLOAD_O,
  output logic [ACC_W-1:0] ACCEL_O,
  output logic ZONE_O,
  output logic [PNUM_W-1:0] POINT_NUM_O,
  output logic STOP_OPEN_O,
  output logic FEEDBACK_CORR_EN_O,
  output logic HOLD_TORQUE_EN_O,
  output logic [TORQ_W-1:0] HOLD_TORQUE_O,
  output logic POWER_SERVO_LAMP_O,
  output logic FAULT_LAMP_O
);

  alarm_sel_if sel ();

  alarm_priority u_alarm_priority (
    .active_i(ALARM_ACTIVE_I),
    .sel(sel.prod)
  );

  logic target_in, cur_in_zone;
  logic accept_q, accept_d, reject_q, reject_d;
  logic [LOAD_W-1:0] payload_q, payload_d;
  logic [ACC_W-1:0] accel_q, accel_d, ceil_sel;
  logic zone_q, zone_d;
  logic [PNUM_W-1:0] pnum_q, pnum_d;
  logic stop_open_q, stop_open_d;
  hold_state_t hold_q, hold_d;
  logic [DLY_W-1:0] dly_q, dly_d;
  logic [TORQ_W-1:0] torque_q, torque_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic [31:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d;
  logic pwr_lamp_q, pwr_lamp_d, err_lamp_q, err_lamp_d;
  logic tick;

  // only the target decides; the resting position is ignored on purpose
  assign target_in = (TARGET_POS_I >= SOFT_LIMIT_LOWER_I) && (TARGET_POS_I <= SOFT_LIMIT_UPPER_I);
  assign cur_in_zone = (CUR_POS_I >= ZONE_LOWER_BOUND_I) && (CUR_POS_I <= ZONE_UPPER_BOUND_I);
  assign ceil_sel = POINT_FLAGS_I[FLAG_PAYLOAD_BIT] ? SECOND_ACCEL_CEIL_I : FIRST_ACCEL_CEIL_I;

  // move check, payload pick and acceleration clamp
  always_comb begin
    accept_d = MOVE_REQ_I && target_in;
    reject_d = MOVE_REQ_I && !target_in;
    payload_d = payload_q;
    accel_d = accel_q;
    if (accept_d) begin
      payload_d = POINT_FLAGS_I[FLAG_PAYLOAD_BIT] ? SECOND_PAYLOAD_SETTING_I
                                                  : FIRST_PAYLOAD_SETTING_I;
      accel_d = REQ_ACCEL_I;
      if (CUSTOM_ACCEL_I && (REQ_ACCEL_I > ceil_sel)) begin
        accel_d = ceil_sel;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      accept_q <= 1'b0;
      reject_q <= 1'b0;
      payload_q <= '0;
      accel_q <= '0;
    end else begin
      accept_q <= accept_d;
      reject_q <= reject_d;
      payload_q <= payload_d;
      accel_q <= accel_d;
    end
  end

  // zone flag and point-number lines
  always_comb begin
    zone_d = cur_in_zone;
    pnum_d = POINT_NUM_I;
    if (ALARM_CODE_OUTPUT_ENABLE_I && sel.active) begin
      pnum_d = sel.code;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      zone_q <= 1'b0;
      pnum_q <= PNUM_RST;
    end else begin
      zone_q <= zone_d;
      pnum_q <= pnum_d;
    end
  end

  // millisecond tick for the hold delay
  assign tick = (tick_cnt_q == 32'(TICK_CNT - 1));

  // stop mode and open-mode holding sequence; a new accepted move drops the hold
  always_comb begin
    tick_cnt_d = tick ? CNT_RST : tick_cnt_q + 32'h1;
    stop_open_d = stop_open_q;
    hold_d = hold_q;
    dly_d = dly_q;
    torque_d = HOLD_TORQUE_SETTING_I;
    case (hold_q)
      HOLD_IDLE: begin
        if (MOVE_DONE_I) begin
          stop_open_d = MOVE_IS_POINT_I ? POINT_FLAGS_I[FLAG_STOP_BIT] : DEFAULT_STOP_MODE_I;
          if (stop_open_d) begin
            hold_d = HOLD_WAIT;
            dly_d = HOLD_DELAY_MS_I;
          end
        end
      end
      HOLD_WAIT: begin
        if (dly_q == DLY_RST) begin
          hold_d = HOLD_ON;
        end else if (tick) begin
          dly_d = dly_q - 16'h1;
        end
      end
      HOLD_ON: hold_d = HOLD_ON;
      default: hold_d = HOLD_IDLE;
    endcase
    if (accept_d) begin
      hold_d = HOLD_IDLE;
      stop_open_d = STOP_OPEN_RST;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      tick_cnt_q <= CNT_RST;
      stop_open_q <= STOP_OPEN_RST;
      hold_q <= HOLD_IDLE;
      dly_q <= DLY_RST;
      torque_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      stop_open_q <= stop_open_d;
      hold_q <= hold_d;
      dly_q <= dly_d;
      torque_q <= torque_d;
    end
  end

  // blink base and lamps; internal alarms rank first so the pick shows their type
  always_comb begin
    blink_cnt_d = blink_cnt_q + 32'h1;
    blink_d = blink_q;
    if (blink_cnt_q == 32'(BLINK_CNT - 1)) begin
      blink_cnt_d = CNT_RST;
      blink_d = !blink_q;
    end
    pwr_lamp_d = CTRL_POWER_I && (SERVO_ON_I || blink_q);
    err_lamp_d = CTRL_POWER_I && sel.active && (!sel.external || blink_q);
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      blink_cnt_q <= CNT_RST;
      blink_q <= 1'b0;
      pwr_lamp_q <= 1'b0;
      err_lamp_q <= 1'b0;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      pwr_lamp_q <= pwr_lamp_d;
      err_lamp_q <= err_lamp_d;
    end
  end

  assign MOVE_ACCEPT_O = accept_q;
  assign MOVE_REJECT_O = reject_q;
  assign PAYLOAD_O = payload_q;
  assign ACCEL_O = accel_q;
  assign ZONE_O = zone_q;
  assign POINT_NUM_O = pnum_q;
  assign STOP_OPEN_O = stop_open_q;
  assign FEEDBACK_CORR_EN_O = !stop_open_q;
  assign HOLD_TORQUE_EN_O = (hold_q == HOLD_ON);
  assign HOLD_TORQUE_O = torque_q;
  assign POWER_SERVO_LAMP_O = pwr_lamp_q;
  assign FAULT_LAMP_O = err_lamp_q;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  a_reject_outside: assert property (
    MOVE_REQ_I && !target_in |=> MOVE_REJECT_O && !MOVE_ACCEPT_O)
    else $error("out of range target not rejected");
  a_accept_inside: assert property (
    MOVE_REQ_I && target_in |=> MOVE_ACCEPT_O && !MOVE_REJECT_O)
    else $error("in range target not accepted");
  a_return_inside: assert property (
    MOVE_REQ_I && target_in && (CUR_POS_I < SOFT_LIMIT_LOWER_I || CUR_POS_I > SOFT_LIMIT_UPPER_I)
    |=> MOVE_ACCEPT_O)
    else $error("return move from outside refused");
  a_zone_track: assert property (
    ZONE_O == $past(cur_in_zone))
    else $error("zone output wrong");
  a_alarm_number: assert property (
    ALARM_CODE_OUTPUT_ENABLE_I && ALARM_ACTIVE_I[1] && !ALARM_ACTIVE_I[0]
    |=> POINT_NUM_O == 8'h82)
    else $error("alarm number missing");
  a_alarm_prio: assert property (
    ALARM_CODE_OUTPUT_ENABLE_I && ALARM_ACTIVE_I[0] |=> POINT_NUM_O == 8'h81)
    else $error("smallest alarm code not chosen");
  a_normal_lines: assert property (
    !ALARM_CODE_OUTPUT_ENABLE_I |=> POINT_NUM_O == $past(POINT_NUM_I))
    else $error("point lines altered while disabled");
  a_payload_pick: assert property (
    MOVE_REQ_I && target_in && POINT_FLAGS_I[0] |=> PAYLOAD_O == $past(SECOND_PAYLOAD_SETTING_I))
    else $error("second payload not applied");
  a_accel_clamp: assert property (
    MOVE_REQ_I && target_in && CUSTOM_ACCEL_I |=> ACCEL_O <= $past(ceil_sel))
    else $error("acceleration above ceiling");
  a_stop_point: assert property (
    MOVE_DONE_I && MOVE_IS_POINT_I && !MOVE_REQ_I |=> STOP_OPEN_O == $past(POINT_FLAGS_I[1]))
    else $error("point stop mode wrong");
  a_stop_default: assert property (
    MOVE_DONE_I && !MOVE_IS_POINT_I && !MOVE_REQ_I |=> STOP_OPEN_O == $past(DEFAULT_STOP_MODE_I))
    else $error("default stop mode not used");
  a_open_nofeedback: assert property (
    HOLD_TORQUE_EN_O |-> STOP_OPEN_O && !FEEDBACK_CORR_EN_O)
    else $error("feedback active in open hold");
  a_servo_lamp: assert property (
    CTRL_POWER_I && SERVO_ON_I |=> POWER_SERVO_LAMP_O)
    else $error("power lamp not lit with servo on");
  a_lamp_dark: assert property (
    !CTRL_POWER_I |=> !POWER_SERVO_LAMP_O && !FAULT_LAMP_O)
    else $error("lamp lit without power");
  a_fault_lamp: assert property (
    CTRL_POWER_I && sel.active && !sel.external |=> FAULT_LAMP_O)
    else $error("fault lamp dark on internal alarm");
  a_blink_period: assert property (
    $changed(blink_q) |-> $past(blink_cnt_q) == 32'(BLINK_CNT - 1))
    else $error("blink toggled off period");

endmodule : axis_guard_status_logic
`default_nettype wire

/* dv/host_plc_model.sv */
// host controller model driving move and done strobes on discrete lines
`timescale 1ns/1ps
`default_nettype none
module host_plc_model
  import axis_guard_pkg::*;
(
  input wire logic clk_i,
  output logic move_req_o,
  output logic signed [POS_W-1:0] target_o,
  output logic [1:0] flags_o,
  output logic is_point_o,
  output logic move_done_o
);
  // idle lines show inverted data so a late sample never looks valid
  initial begin
    move_req_o = 1'b0;
    move_done_o = 1'b0;
    target_o = 32'h5A5A5A5A;
    flags_o = 2'h3;
    is_point_o = 1'b0;
  end
  // one-cycle move request with target and flags held alongside
  task automatic move(input logic signed [POS_W-1:0] t, input logic [1:0] f);
    @(posedge clk_i);
    #1;
    move_req_o = 1'b1;
    target_o = t;
    flags_o = f;
    @(posedge clk_i);
    #1;
    move_req_o = 1'b0;
    target_o = ~t;
    flags_o = ~f;
  endtask : move
  // one-cycle completion report with the move kind and flags
  task automatic finish(input logic pt, input logic [1:0] f);
    @(posedge clk_i);
    #1;
    move_done_o = 1'b1;
    is_point_o = pt;
    flags_o = f;
    @(posedge clk_i);
    #1;
    move_done_o = 1'b0;
    is_point_o = ~pt;
    flags_o = ~f;
  endtask : finish
endmodule : host_plc_model
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the axis guard and status logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  import axis_guard_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic signed [POS_W-1:0] cur = 32'h0;
  logic cust = 1'b1;
  logic dflt = 1'b1;
  logic aen = 1'b0;
  logic power_servo_lamp = 1'b0;
  logic srv = 1'b0;
  logic [NUM_ALARMS-1:0] alarms = 20'h0;
  logic signed [POS_W-1:0] lo = -32'sd100;
  logic signed [POS_W-1:0] hi = 32'sd100;
  logic [15:0] ceil1 = 16'h00A0;
  logic [15:0] racc = 16'h0100;
  logic [15:0] torq = 16'h0055;
  logic [15:0] hdly = 16'h0000;
  logic [7:0] pnum = 8'h3C;
  logic req, done, is_pt, acc_o, rej_o, zone_o, open_o, fb_o, hen_o, plamp, flamp;
  logic signed [POS_W-1:0] tgt;
  logic [1:0] flags;
  logic [15:0] pay_o, accel_o, tq_o;
  logic [7:0] pn_o;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int n1, n2;
  always #2 clk = ~clk;
  host_plc_model host_plc_model_i (.clk_i(clk), .move_req_o(req), .target_o(tgt),
    .flags_o(flags), .is_point_o(is_pt), .move_done_o(done));
  // short blink and tick counts keep the run brief
  axis_guard_status_logic #(.BLINK_CNT(8), .TICK_CNT(4)) axis_guard_status_logic_i (
    .MCLK_I(clk), .RSTN_I(rstn), .SOFT_LIMIT_LOWER_I(lo),
    .SOFT_LIMIT_UPPER_I(hi), .ZONE_LOWER_BOUND_I(32'sd10), .ZONE_UPPER_BOUND_I(32'sd20),
    .CUR_POS_I(cur), .TARGET_POS_I(tgt), .MOVE_REQ_I(req), .MOVE_IS_POINT_I(is_pt),
    .POINT_FLAGS_I(flags), .FIRST_PAYLOAD_SETTING_I(16'h001E),
    .SECOND_PAYLOAD_SETTING_I(16'h0003), .FIRST_ACCEL_CEIL_I(ceil1),
    .SECOND_ACCEL_CEIL_I(16'h0190), .CUSTOM_ACCEL_I(cust), .REQ_ACCEL_I(racc),
    .MOVE_DONE_I(done), .DEFAULT_STOP_MODE_I(dflt), .HOLD_TORQUE_SETTING_I(torq),
    .HOLD_DELAY_MS_I(hdly), .POINT_NUM_I(pnum), .ALARM_CODE_OUTPUT_ENABLE_I(aen),
    .ALARM_ACTIVE_I(alarms), .CTRL_POWER_I(power_servo_lamp), .SERVO_ON_I(srv), .MOVE_ACCEPT_O(acc_o),
    .MOVE_REJECT_O(rej_o), .PAYLOAD_O(pay_o), .ACCEL_O(accel_o), .ZONE_O(zone_o),
    .POINT_NUM_O(pn_o), .STOP_OPEN_O(open_o), .FEEDBACK_CORR_EN_O(fb_o),
    .HOLD_TORQUE_EN_O(hen_o), .HOLD_TORQUE_O(tq_o), .POWER_SERVO_LAMP_O(plamp),
    .FAULT_LAMP_O(flamp));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // samples both lamps over 32 cycles, two full blink periods
  task automatic lamps(output int p, output int f);
    p = 0;
    f = 0;
    repeat (32) begin
      step(1);
      p += int'(plamp === 1'b1);
      f += int'(flamp === 1'b1);
    end
  endtask : lamps
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  int tg[6] = '{-101, -100, 100, 101, 0, 150};
  logic [NUM_ALARMS-1:0] al[6] = '{20'h00020, 20'h00020, 20'h80022, 20'h40003, 20'h00000,
    20'h80000};
  logic [7:0] pe[6] = '{8'h3C, 8'h86, 8'h82, 8'h81, 8'h3C, 8'hC2};
  initial begin
    step(8);
    rstn = 1'b1;
    chk("feedback", 1, fb_o);
    chk("stop", 0, open_o);
    // limit edges are inclusive; the last target runs from outside the range
    foreach (tg[i]) begin
      if (i == 5) host_plc_model_i.move(32'sd50, 2'b00);
      if (i == 5) chk("return", 1, acc_o);
      if (i == 4) cur = 32'sd200;
      host_plc_model_i.move(tg[i], 2'b00);
      chk("accept", (tg[i] >= -100 && tg[i] <= 100), acc_o);
      chk("reject", !(tg[i] >= -100 && tg[i] <= 100), rej_o);
    end
    // narrowed limits must move the reject boundary with them
    hi = 32'sd40;
    host_plc_model_i.move(32'sd50, 2'b00);
    chk("reject", 1, rej_o);
    lo = -32'sd10;
    host_plc_model_i.move(-32'sd20, 2'b00);
    chk("reject", 1, rej_o);
    $display("test limits done");
    host_plc_model_i.move(0, 2'b01);
    chk("payload", 16'h0003, pay_o);
    chk("accel", 16'h0100, accel_o);
    racc = 16'h0200;
    host_plc_model_i.move(0, 2'b01);
    chk("accel", 16'h0190, accel_o);
    racc = 16'h0100;
    host_plc_model_i.move(0, 2'b00);
    chk("payload", 16'h001E, pay_o);
    chk("accel", 16'h00A0, accel_o);
    cust = 1'b0;
    host_plc_model_i.move(0, 2'b00);
    chk("accel", 16'h0100, accel_o);
    $display("test payload done");
    foreach (tg[i]) begin
      cur = 32'(10 + i * 3);
      step(1);
      chk("zone", (i < 4), zone_o);
    end
    $display("test zone done");
    host_plc_model_i.finish(1'b0, 2'b00);
    chk("stop", 1, open_o);
    chk("feedback", 0, fb_o);
    step(3);
    chk("hold", 1, hen_o);
    chk("torque", 16'h0055, tq_o);
    host_plc_model_i.move(0, 2'b00);
    chk("stop", 0, open_o);
    host_plc_model_i.finish(1'b1, 2'b00);
    chk("stop", 0, open_o);
    dflt = 1'b0;
    host_plc_model_i.move(0, 2'b00);
    host_plc_model_i.finish(1'b0, 2'b10);
    chk("stop", 0, open_o);
    // three ms ticks of four cycles; tick phase is free running, so hold lands 10 to 13 later
    hdly = 16'h0003;
    torq = 16'h00AA;
    host_plc_model_i.finish(1'b1, 2'b10);
    chk("stop", 1, open_o);
    step(7);
    chk("hold", 0, hen_o);
    step(6);
    chk("hold", 1, hen_o);
    chk("torque", 16'h00AA, tq_o);
    $display("test stop done");
    foreach (al[i]) begin
      aen = (i != 0);
      alarms = al[i];
      step(1);
      chk("point", pe[i], pn_o);
    end
    $display("test alarm done");
    lamps(n1, n2);
    chk("power lamp", 0, n1);
    chk("fault lamp", 0, n2);
    power_servo_lamp = 1'b1;
    srv = 1'b1;
    alarms = 20'h00004;
    lamps(n1, n2);
    chk("power lamp", 32, n1);
    chk("fault lamp", 32, n2);
    srv = 1'b0;
    alarms = 20'h40000;
    lamps(n1, n2);
    chk("power lamp", 16, n1);
    chk("fault lamp", 16, n2);
    alarms = 20'h0;
    lamps(n1, n2);
    chk("fault lamp", 0, n2);
    $display("test lamps done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
